// ==== verilog/tsic_map.svh ====
`ifndef TSIC_MAP_SVH
`define TSIC_MAP_SVH

// Address byte layout
`define TSIC_ADDR_PATTERN 5'h18
`define TSIC_ADDR_FIXED_SEL 2'h1

// First byte of a pair: selector in the most significant bit
`define TSIC_PAIR_SEL_BIT 7

// Control byte fields (bit 0 is the last bit on the wire)
`define TSIC_CTL_PUMP_CUR 6
`define TSIC_CTL_TEST_EN 5
`define TSIC_CTL_PUMP_DIS 4
`define TSIC_CTL_TEST_SEL2 3
`define TSIC_CTL_TEST_SEL1 2
`define TSIC_CTL_TEST_SEL0 1
`define TSIC_CTL_AMP_OFF 0

// Port byte: ports 0 and 3 to 7 are programmable
`define TSIC_PORT_MASK 8'hF9

// Status byte fields
`define TSIC_ST_POR 7
`define TSIC_ST_LOCK 6

// Reset values
`define TSIC_RATIO_RST 15'h0000
`define TSIC_CTRL_RST 8'h00
`define TSIC_PORT_RST 8'h00

// Serial byte framing
`define TSIC_BITS_BYTE 4'h8
`define TSIC_BIT_LAST 4'h7

// Reference divider ratios and prescaler
`define TSIC_REFDIV_SHORT 11'h200
`define TSIC_REFDIV_LONG 11'h400
`define TSIC_PRESCALE 5'h10

`endif

// ==== verilog/tsic_pkg.sv ====
`default_nettype none

package tsic_pkg;

  typedef enum logic [2:0] {
    TSIC_IDLE,
    TSIC_ADDR,
    TSIC_ADDR_ACK,
    TSIC_WR_BYTE,
    TSIC_WR_ACK,
    TSIC_RD_BYTE,
    TSIC_RD_ACK
  } tsic_state_e;

  // Levels sensed from the analog front end and pins
  typedef struct packed {
    logic [1:0] addr_sel;
    logic [2:0] conv_code;
    logic port7_level;
    logic port5_level;
    logic port4_level;
    logic lock_flag;
    logic supply_low;
  } tsic_sense_s;

  // Loop and test controls toward the analog parts
  typedef struct packed {
    logic pump_high_current;
    logic pump_disable;
    logic drive_amp_off;
    logic test_enable;
    logic test_sel0_refdiv;
    logic pump_force_source;
    logic pump_force_sink;
    logic ports_test_x;
    logic port7_fpd_half;
    logic port7_fpd_port6_fcomp;
  } tsic_ctrl_s;

endpackage : tsic_pkg

`default_nettype wire

// ==== verilog/tsic_top.sv ====
`include "tsic_map.svh"

`default_nettype none

// Overview of operation
// - Answers fixed address plus one selectable address
// - Port three level selects the matched address
// - Address byte is 11000, select bits, R/W
// - R/W low writes, high reads
// - Acknowledge address and every written byte
// - No acknowledge after status ends the read
// - Pair first byte msb selects frequency/control
// - Second byte is ratio low or port
// - Pairs repeat until bus stop
// - Partial byte discarded, old value kept
// - Fifteen-bit divide ratio register
// - Divide ratio follows fixed divide-by-sixteen prescaler
// - Reference divides 512 or 1024
// - Control bit selects pump current
// - Lock forces low pump current
// - Control bit disables charge pump
// - Control bit switches drive amplifier off
// - Test enable plus three select bits
// - Without test enable only ratio bit used
// - Port byte bit one sinks, zero floats
// - Status byte sent msb first
// - Power-on flag: set on supply loss
// - Status reports phase lock
// - Status carries port levels and converter code
module tsic_top #(
  parameter int RATIO_W = 15,
  parameter int REF_W = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ref_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire tsic_pkg::tsic_sense_s sense,
  output logic [RATIO_W-1:0] divide_ratio,
  output tsic_pkg::tsic_ctrl_s ctrl,
  output logic [7:0] port_sink,
  output logic comp_clk,
  output logic por_flag
);

  localparam int SYNC_W = 2 + $bits(tsic_pkg::tsic_sense_s);
  localparam logic [REF_W-1:0] HALF_SHORT = REF_W'(`TSIC_REFDIV_SHORT / 2 - 1);
  localparam logic [REF_W-1:0] HALF_LONG = REF_W'(`TSIC_REFDIV_LONG / 2 - 1);

  // Byte shifter advance, msb first on the wire
  function automatic logic [7:0] shift_byte(input logic [7:0] v, input logic b);
    return {v[6:0], b};
  endfunction : shift_byte

  // Open drain data: pull the line low for a zero bit
  function automatic logic pull_for(input logic b);
    return ~b;
  endfunction : pull_for

  // Bit counter advance
  function automatic logic [3:0] count_up(input logic [3:0] c);
    return c + 4'h1;
  endfunction : count_up

  // Input synchronisers
  // Bus lines and sensed levels share one two-flop chain
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic scl_prev_q;
  logic sda_prev_q;

  always_ff @(posedge sys_clk) begin
    sync1_q <= {scl_in, sda_in, sense};
    sync2_q <= sync1_q;
    scl_prev_q <= sync2_q[SYNC_W-1];
    sda_prev_q <= sync2_q[SYNC_W-2];
  end

  wire scl_s = sync2_q[SYNC_W-1];
  wire sda_s = sync2_q[SYNC_W-2];
  tsic_pkg::tsic_sense_s sense_s;
  assign sense_s = sync2_q[SYNC_W-3:0];

  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // State
  tsic_pkg::tsic_state_e state_q;
  tsic_pkg::tsic_state_e state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic oe_q;
  logic oe_d;
  logic rw_q;
  logic rw_d;
  logic byte_done;
  logic rd_xfer_q;
  logic rd_xfer_d;
  logic pair_second_q;
  logic pair_ctrl_q;
  logic por_q;
  logic [RATIO_W-1:0] ratio_q;
  logic [7:0] loop_control_q;
  logic [7:0] port_outputs_q;
  tsic_pkg::tsic_ctrl_s ctrl_q;
  tsic_pkg::tsic_ctrl_s ctrl_d;
  logic [7:0] port_sink_q;

  // Control byte fields
  wire ts_en = loop_control_q[`TSIC_CTL_TEST_EN];
  wire ts2 = loop_control_q[`TSIC_CTL_TEST_SEL2];
  wire ts1 = loop_control_q[`TSIC_CTL_TEST_SEL1];
  wire ts0 = loop_control_q[`TSIC_CTL_TEST_SEL0];

  // Test mode decodes; all quiet while test enable is low
  wire mode_pump_src = ts_en && !ts2 && !ts1;
  wire mode_pump_snk = ts_en && !ts2 && ts1;
  wire mode_ports_x = ts_en && ts2;
  wire mode_fpd_half = ts_en && ts2 && !ts1 && ts0;
  wire mode_fpd_full = ts_en && ts2 && ts1;

  // Lock as reported; forced by pump test modes
  wire lock_report = (ts_en && !ts2) ? ts1 : sense_s.lock_flag;

  wire [7:0] status_byte = {por_q, lock_report, sense_s.port7_level,
    sense_s.port5_level, sense_s.port4_level, sense_s.conv_code};

  // Fixed select always answers; the sensed select adds one more
  wire addr_pat_ok = (shift_q[7:3] == `TSIC_ADDR_PATTERN);
  wire addr_sel_ok = (shift_q[2:1] == `TSIC_ADDR_FIXED_SEL) ||
    (shift_q[2:1] == sense_s.addr_sel);
  wire addr_hit = addr_pat_ok && addr_sel_ok;

  // Bus engine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    oe_d = oe_q;
    rw_d = rw_q;
    rd_xfer_d = rd_xfer_q;
    byte_done = 1'b0;
    if (stop_det) begin
      state_d = tsic_pkg::TSIC_IDLE;
      oe_d = 1'b0;
      rd_xfer_d = 1'b0;
    end else if (start_det) begin
      state_d = tsic_pkg::TSIC_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
      rd_xfer_d = 1'b0;
    end else begin
      case (state_q)
        tsic_pkg::TSIC_ADDR, tsic_pkg::TSIC_WR_BYTE: begin
          if (scl_rise && cnt_q != `TSIC_BITS_BYTE) begin
            shift_d = shift_byte(shift_q, sda_s);
            cnt_d = count_up(cnt_q);
          end else if (scl_fall && cnt_q == `TSIC_BITS_BYTE) begin
            if (state_q == tsic_pkg::TSIC_ADDR) begin
              if (addr_hit) begin
                oe_d = 1'b1;
                rw_d = shift_q[0];
                state_d = tsic_pkg::TSIC_ADDR_ACK;
              end else begin
                state_d = tsic_pkg::TSIC_IDLE;
              end
            end else begin
              byte_done = 1'b1;
              oe_d = 1'b1;
              state_d = tsic_pkg::TSIC_WR_ACK;
            end
          end
        end
        tsic_pkg::TSIC_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              shift_d = status_byte;
              oe_d = pull_for(status_byte[7]);
              rd_xfer_d = 1'b1;
              state_d = tsic_pkg::TSIC_RD_BYTE;
            end else begin
              oe_d = 1'b0;
              state_d = tsic_pkg::TSIC_WR_BYTE;
            end
          end
        end
        tsic_pkg::TSIC_WR_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            cnt_d = 4'h0;
            state_d = tsic_pkg::TSIC_WR_BYTE;
          end
        end
        tsic_pkg::TSIC_RD_BYTE: begin
          if (scl_fall) begin
            if (cnt_q == `TSIC_BIT_LAST) begin
              oe_d = 1'b0;
              state_d = tsic_pkg::TSIC_RD_ACK;
            end else begin
              shift_d = shift_byte(shift_q, 1'b0);
              oe_d = pull_for(shift_q[6]);
              cnt_d = count_up(cnt_q);
            end
          end
        end
        // Master acknowledge reloads a fresh status byte
        tsic_pkg::TSIC_RD_ACK: begin
          if (scl_rise && sda_s) begin
            state_d = tsic_pkg::TSIC_IDLE;
          end else if (scl_fall) begin
            shift_d = status_byte;
            oe_d = pull_for(status_byte[7]);
            cnt_d = 4'h0;
            state_d = tsic_pkg::TSIC_RD_BYTE;
          end
        end
        default: begin
          state_d = tsic_pkg::TSIC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= tsic_pkg::TSIC_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      oe_q <= 1'b0;
      rw_q <= 1'b0;
      rd_xfer_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      oe_q <= oe_d;
      rw_q <= rw_d;
      rd_xfer_q <= rd_xfer_d;
    end
  end

  // Byte pairing
  wire first_is_ctrl = shift_q[`TSIC_PAIR_SEL_BIT];
  wire wr_ratio_hi = byte_done && !pair_second_q && !first_is_ctrl;
  wire wr_ctrl = byte_done && !pair_second_q && first_is_ctrl;
  wire wr_ratio_lo = byte_done && pair_second_q && !pair_ctrl_q;
  wire wr_port = byte_done && pair_second_q && pair_ctrl_q;

  always_ff @(posedge sys_clk) begin
    if (rst || start_det || stop_det) begin
      pair_second_q <= 1'b0;
      pair_ctrl_q <= 1'b0;
    end else if (byte_done) begin
      pair_second_q <= ~pair_second_q;
      pair_ctrl_q <= pair_second_q ? pair_ctrl_q : first_is_ctrl;
    end
  end

  // Programmed registers; lost on supply loss
  always_ff @(posedge sys_clk) begin
    if (rst || sense_s.supply_low) begin
      ratio_q <= `TSIC_RATIO_RST;
      loop_control_q <= `TSIC_CTRL_RST;
      port_outputs_q <= `TSIC_PORT_RST;
    end else begin
      if (wr_ratio_hi) begin
        ratio_q[RATIO_W-1:8] <= shift_q[RATIO_W-9:0];
      end
      if (wr_ratio_lo) begin
        ratio_q[7:0] <= shift_q;
      end
      if (wr_ctrl) begin
        loop_control_q <= shift_q;
      end
      if (wr_port) begin
        port_outputs_q <= shift_q;
      end
    end
  end

  // Power-on flag: set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      por_q <= 1'b1;
    end else if (sense_s.supply_low) begin
      por_q <= 1'b1;
    end else if (stop_det && rd_xfer_q) begin
      por_q <= 1'b0;
    end
  end

  // Control decode
  always_comb begin
    ctrl_d = '0;
    ctrl_d.pump_high_current = loop_control_q[`TSIC_CTL_PUMP_CUR] &
      ~sense_s.lock_flag;
    ctrl_d.pump_disable = loop_control_q[`TSIC_CTL_PUMP_DIS];
    ctrl_d.drive_amp_off = loop_control_q[`TSIC_CTL_AMP_OFF];
    ctrl_d.test_enable = ts_en;
    ctrl_d.test_sel0_refdiv = ts0;
    ctrl_d.pump_force_source = mode_pump_src;
    ctrl_d.pump_force_sink = mode_pump_snk;
    ctrl_d.ports_test_x = mode_ports_x;
    ctrl_d.port7_fpd_half = mode_fpd_half;
    ctrl_d.port7_fpd_port6_fcomp = mode_fpd_full;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= '0;
      port_sink_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      port_sink_q <= por_q ? 8'h00 : (port_outputs_q & `TSIC_PORT_MASK);
    end
  end

  // Ratio drives the divider behind the fixed prescaler
  assign divide_ratio = ratio_q;
  assign ctrl = ctrl_q;
  assign port_sink = port_sink_q;
  assign por_flag = por_q;
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  // Reference divider on the reference clock
  logic rrst1_q;
  logic rrst2_q;
  logic rsel1_q;
  logic rsel2_q;
  logic [REF_W-1:0] ref_cnt_q;
  logic comp_q;

  // Reset and ratio select cross into the reference domain by two flops
  always_ff @(posedge ref_clk) begin
    rrst1_q <= rst;
    rrst2_q <= rrst1_q;
    rsel1_q <= ctrl_q.test_sel0_refdiv;
    rsel2_q <= rsel1_q;
  end

  wire [REF_W-1:0] ref_half = rsel2_q ? HALF_SHORT : HALF_LONG;
  // Greater-or-equal lets a shorter ratio wrap at once mid-count
  wire ref_wrap = (ref_cnt_q >= ref_half);

  always_ff @(posedge ref_clk) begin
    if (rrst2_q) begin
      ref_cnt_q <= '0;
      comp_q <= 1'b0;
    end else if (ref_wrap) begin
      ref_cnt_q <= '0;
      comp_q <= ~comp_q;
    end else begin
      ref_cnt_q <= ref_cnt_q + REF_W'(1);
    end
  end

  assign comp_clk = comp_q;

endmodule : tsic_top

`default_nettype wire

// ==== testbench/tsic_top_props.sv ====
`default_nettype none
module tsic_top_props #(
  parameter int RATIO_W = 15
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ref_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire tsic_pkg::tsic_sense_s sense,
  input wire logic [RATIO_W-1:0] divide_ratio,
  input wire tsic_pkg::tsic_ctrl_s ctrl,
  input wire logic [7:0] port_sink,
  input wire logic comp_clk,
  input wire logic por_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] half_q;
  logic comp_q;
  // Reference cycles since the comparison clock last changed
  always_ff @(posedge ref_clk) begin
    comp_q <= comp_clk;
    half_q <= (rst || comp_q != comp_clk) ? 11'h000 : half_q + 11'h001;
  end
  sequence s_locked;
    sense.lock_flag[*5];
  endsequence
  sequence s_supply_lost;
    sense.supply_low[*5];
  endsequence
  a_unused_ports: assert property (@(posedge sys_clk) disable iff (rst)
    port_sink[2:1] == 2'h0) else $error("ports one or two sinking");
  a_por_floats: assert property (@(posedge sys_clk) disable iff (rst)
    por_flag && $past(por_flag) |-> port_sink == 8'h00) else $error("port on during por");
  a_supply_sets_por: assert property (@(posedge sys_clk) disable iff (rst)
    s_supply_lost |-> por_flag) else $error("supply loss did not set por");
  a_lock_low_current: assert property (@(posedge sys_clk) disable iff (rst)
    s_locked |-> !ctrl.pump_high_current) else $error("high current while locked");
  a_test_off_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    !ctrl.test_enable |-> ctrl[4:0] == 5'h00) else $error("test decode without enable");
  a_ack_in_low: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(sda_oe) |-> !scl_in ##0 sda_oe[*8]) else $error("data pull badly timed");
  a_release_low: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(sda_oe) |-> !scl_in) else $error("data released with clock high");
  a_por_on_stop: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(por_flag) |-> scl_in && sda_in) else $error("por cleared outside stop");
  a_comp_toggle: assert property (@(posedge ref_clk) disable iff (rst)
    half_q < 11'h208) else $error("comparison clock half period too long");
endmodule : tsic_top_props
bind tsic_top tsic_top_props #(.RATIO_W(RATIO_W)) tsic_top_props_inst (
  .sys_clk, .rst, .ref_clk, .scl_in, .sda_in, .sda_out, .sda_oe, .sense,
  .divide_ratio, .ctrl, .port_sink, .comp_clk, .por_flag
);
`default_nettype wire

// ==== testbench/tsic_bus_ctl.sv ====
`default_nettype none
module tsic_bus_ctl (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : hold
  // Start or repeated start; leaves the clock low
  task automatic start_c();
    sda_low = 1'b0;
    hold(8);
    scl = 1'b1;
    hold(8);
    sda_low = 1'b1;
    hold(8);
    scl = 1'b0;
    hold(2);
  endtask : start_c
  task automatic stop_c();
    sda_low = 1'b1;
    hold(8);
    scl = 1'b1;
    hold(8);
    sda_low = 1'b0;
    hold(8);
  endtask : stop_c
  task automatic bit_c(input logic b, output logic r);
    sda_low = !b;
    hold(8);
    scl = 1'b1;
    hold(8);
    r = sda;
    scl = 1'b0;
    hold(2);
  endtask : bit_c
  task automatic byte_c(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack);
    for (int i = 7; i >= 0; i--) bit_c(d[i], q[i]);
    bit_c(ack_in, ack);
  endtask : byte_c
endmodule : tsic_bus_ctl
`default_nettype wire

// ==== testbench/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_low, sda_oe, sda_out, comp_clk, por_flag;
  wire logic sda = !(sda_low || (sda_oe && !sda_out));
  tsic_pkg::tsic_sense_s sense = '0;
  tsic_pkg::tsic_ctrl_s ctrl;
  logic [14:0] divide_ratio;
  logic [7:0] port_sink;
  logic [31:0] seed = 32'h43;
  logic [7:0] codes[9] = '{8'hCC, 8'hCE, 8'h8C, 8'hE2, 8'hE6, 8'hEA, 8'hEE, 8'hDE, 8'hCF};
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int e_ratio = 0, e_ctl = 0, e_port = 0, e_por = 1;
  initial forever #12.5 sys_clk = !sys_clk;
  initial begin
    #3.1;
    forever #6 ref_clk = !ref_clk;
  end
  tsic_top tsic_top_inst (
    .sys_clk(sys_clk), .rst(rst), .ref_clk(ref_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .sense(sense), .divide_ratio(divide_ratio),
    .ctrl(ctrl), .port_sink(port_sink), .comp_clk(comp_clk), .por_flag(por_flag)
  );
  tsic_bus_ctl tsic_bus_ctl_inst (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [9:0] ctl_exp();
    logic [7:0] c;
    logic t;
    c = 8'(e_ctl);
    t = c[5];
    return {c[6] & !sense.lock_flag, c[4], c[0], t, c[1], t & !c[3] & !c[2],
      t & !c[3] & c[2], t & c[3], t & c[3] & !c[2] & c[1], t & c[3] & c[2]};
  endfunction : ctl_exp
  function automatic logic [7:0] st_exp();
    logic [7:0] c;
    c = 8'(e_ctl);
    return {e_por[0], ((c[5] && !c[3]) ? c[2] : sense.lock_flag), sense.port7_level,
      sense.port5_level, sense.port4_level, sense.conv_code};
  endfunction : st_exp
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic snd(input logic [7:0] d, input logic ack_want);
    logic [7:0] q;
    logic a;
    tsic_bus_ctl_inst.byte_c(d, 1'b1, q, a);
    check(16'(a), 16'(!ack_want));
  endtask : snd
  task automatic regs_chk();
    repeat (4) @(posedge sys_clk);
    #2;
    check(16'(divide_ratio), 16'(e_ratio));
    check(16'(port_sink), e_por ? 16'h0000 : 16'(e_port & 'hF9));
    check(16'(ctrl), 16'(ctl_exp()));
    check(16'(por_flag), 16'(e_por));
  endtask : regs_chk
  task automatic comp_chk();
    int n;
    logic c;
    n = 0;
    @(comp_clk);
    c = comp_clk;
    while (comp_clk == c) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(16'(n), e_ctl[1] ? 16'h0100 : 16'h0200);
    @(posedge sys_clk);
    #2;
  endtask : comp_chk
  task automatic wr(input logic [7:0] c);
    logic [31:0] r;
    r = rnd();
    tsic_bus_ctl_inst.start_c();
    snd(8'hC2, 1'b1);
    snd({1'b0, r[14:8]}, 1'b1);
    snd(r[7:0], 1'b1);
    snd(c, 1'b1);
    snd(r[23:16], 1'b1);
    tsic_bus_ctl_inst.stop_c();
    e_ratio = r[14:0];
    e_ctl = c;
    e_port = r[23:16];
    regs_chk();
    comp_chk();
  endtask : wr
  task automatic rd();
    logic [31:0] r;
    logic [7:0] q;
    logic a;
    r = rnd();
    {sense.conv_code, sense.port7_level, sense.port5_level, sense.port4_level} = r[5:0];
    tsic_bus_ctl_inst.start_c();
    snd(8'hC3, 1'b1);
    for (int k = 0; k < 2; k++) begin
      tsic_bus_ctl_inst.byte_c(8'hFF, 1'(k), q, a);
      check(16'(q), 16'(st_exp()));
    end
    tsic_bus_ctl_inst.bit_c(1'b1, a);
    check(16'(a), 16'h0001);
    tsic_bus_ctl_inst.stop_c();
    e_por = 0;
    regs_chk();
  endtask : rd
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 70000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    logic a;
    sense.addr_sel = 2'h3;
    repeat (8) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    regs_chk();
    rd();
    for (int l = 0; l < 2; l++) begin
      sense.lock_flag = 1'(l);
      foreach (codes[i]) begin
        wr(codes[i]);
        rd();
      end
    end
    for (int s = 0; s < 5; s++) begin
      tsic_bus_ctl_inst.start_c();
      snd(s < 4 ? {5'h18, 2'(s), 1'b0} : 8'h82, s == 1 || s == 3);
      tsic_bus_ctl_inst.stop_c();
    end
    tsic_bus_ctl_inst.start_c();
    snd(8'hC2, 1'b1);
    snd(8'h55, 1'b1);
    repeat (4) tsic_bus_ctl_inst.bit_c(1'b0, a);
    tsic_bus_ctl_inst.stop_c();
    e_ratio = (e_ratio & 'hFF) | ('h55 << 8);
    regs_chk();
    sense.supply_low = 1'b1;
    repeat (10) @(posedge sys_clk);
    #2;
    sense.supply_low = 1'b0;
    e_ratio = 0;
    e_ctl = 0;
    e_port = 0;
    e_por = 1;
    regs_chk();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
